// ==== logic/timer_pkg.sv ====
// Shared constants, types and helpers for the sixteen-bit event-reset timer.
// Assumes a single core clock and byte-wide registers on 32-bit APB words.
package timer_pkg;

   // Register byte addresses
   localparam logic [7:0] OFS_COUNT_LOW = 8'h00;
   localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
   localparam logic [7:0] OFS_CONTROL = 8'h08;
   localparam logic [7:0] OFS_FLAG = 8'h0c;
   localparam logic [7:0] OFS_ENABLE = 8'h10;
   localparam logic [7:0] OFS_OSC = 8'h14;

   // counter_control fields
   localparam int unsigned CTL_ON = 0;
   localparam int unsigned CTL_SRC = 1;
   localparam int unsigned CTL_SYNC_BYP = 2;
   localparam int unsigned CTL_XTAL = 3;
   localparam int unsigned CTL_PS_LO = 4;
   localparam int unsigned CTL_PS_HI = 5;
   localparam int unsigned CTL_RUN = 6;
   localparam int unsigned CTL_WIDE = 7;
   localparam logic [7:0] CTL_WMASK = 8'hbf;

   // Flag, enable and oscillator control fields
   localparam int unsigned FLAG_OVF = 0;
   localparam int unsigned EN_OVF = 0;
   localparam int unsigned OSC_SEL_LO = 0;
   localparam int unsigned OSC_SEL_HI = 1;
   localparam int unsigned OSC_IDLE = 7;

   localparam logic [1:0] SCS_SECONDARY = 2'b01;
   localparam logic [3:0] MODE_SPECIAL_EVENT = 4'b1011;
   localparam logic [15:0] COUNT_MAX = 16'hffff;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam int unsigned INSTR_DIV = 4;

   typedef enum logic [1:0] {
      PM_PRIMARY = 2'b00,
      PM_SEC_RUN = 2'b01,
      PM_SEC_IDLE = 2'b10
   } power_mode_e;

   typedef struct packed {
      logic [3:0] mode;
      logic fire;
   } cmp_trig_s;

   function automatic logic is_special_event(input cmp_trig_s t);
      return (t.mode == MODE_SPECIAL_EVENT) && t.fire;
   endfunction : is_special_event

endpackage : timer_pkg

// ==== logic/tick_source.sv ====
// Raw count tick: instruction-cycle enable or rising edge of a clock pin.
// Assumes pin levels already synchronous to core_clk.
`timescale 1ns/10ps
module tick_source
   import timer_pkg::*;
#(
   parameter int unsigned DIV = INSTR_DIV
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Selection
   input wire logic src_sel,
   input wire logic xtal_en,
   // Clock pins
   input wire logic ext_clk_in,
   input wire logic osc_clk_in,
   // Tick
   output logic raw_tick
);
   typedef struct packed {
      logic [$clog2(DIV)-1:0] div;
      logic prev;
   } src_state_s;

   src_state_s s_q;
   src_state_s s_d;
   logic level;
   logic div_end;

   always_comb begin
      s_d = s_q;
      level = xtal_en ? osc_clk_in : ext_clk_in;
      div_end = (s_q.div == ($clog2(DIV))'(DIV - 1));
      s_d.prev = level;
      s_d.div = div_end ? '0 : s_q.div + 1'b1;
      raw_tick = src_sel ? (level && !s_q.prev) : div_end;
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : tick_source

// ==== logic/prescaler.sv ====
// Divides the raw count tick by 1, 2, 4 or 8.
// Assumes tick is a one-cycle enable; clear restarts the division.
`timescale 1ns/10ps
module prescaler
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Control
   input wire logic [1:0] sel,
   input wire logic clear,
   // Ticks
   input wire logic tick,
   output logic out_tick
);
   typedef struct packed {
      logic [2:0] cnt;
   } ps_state_s;

   ps_state_s s_q;
   ps_state_s s_d;
   logic [2:0] mask;

   always_comb begin
      s_d = s_q;
      case (sel)
         2'b00: mask = 3'h0;
         2'b01: mask = 3'h1;
         2'b10: mask = 3'h3;
         default: mask = 3'h7;
      endcase
      out_tick = tick && ((s_q.cnt & mask) == mask) && !clear;
      if (clear) begin
         s_d.cnt = '0;
      end else if (tick) begin
         s_d.cnt = s_q.cnt + 3'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : prescaler

// ==== logic/event_timer.sv ====
// Sixteen-bit event-reset timer with APB registers and clock status.
// Assumes compare units, clock pins and power controller are outside.
//
// Notes on behaviour
// - Clock select 01 enters secondary run, clocking from the crystal.
// - In secondary run, sleep with idle bit clear enters secondary idle.
// - Secondary clock active reads one only while crystal clocks the device.
// - With monitor on, crystal failure clears the secondary clock active bit.
// - Low-power configuration bit selects reduced oscillator power; default is high.
// - Count climbs through every value and wraps from maximum to zero.
// - Wrap sets overflow flag, held until software clears it.
// - Interrupt request only while overflow enable bit is set.
// - Special event from either compare unit clears the count.
// - Trigger reset works in timer and synchronous modes, not asynchronous.
// - Compare value thus acts as the counter period.
// - Count write in same cycle as trigger wins; trigger ignored.
// - Trigger reset from second compare unit never sets overflow flag.
// - Second unit trigger starts conversion when converter enabled.
// - Writing high byte alone leaves low byte and running count intact.
// - Wide mode: low read buffers high byte; low write loads buffer.
// - Source select picks instruction cycles or external rising edges.
// - Prescale field divides input by 1, 2, 4 or 8.
// - Counter advances only while on bit is set; clearing holds value.
`timescale 1ns/10ps
module event_timer
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Clock pins
   input wire logic ext_clk_in,
   input wire logic osc_clk_in,
   // Compare units and converter
   input wire cmp_trig_s cmp_one,
   input wire cmp_trig_s cmp_two,
   input wire logic adc_enable,
   output logic adc_start,
   // Power management
   input wire logic sleep_exec,
   input wire logic wake_event,
   input wire logic monitor_enable,
   input wire logic osc_fail,
   input wire logic low_power_cfg,
   output logic [1:0] system_clock_select,
   output logic sec_run_mode,
   output logic sec_idle_mode,
   output logic secondary_clock_active,
   output logic osc_low_power_mode,
   output logic crystal_osc_on,
   // Interrupt request
   output logic overflow_irq
);
   typedef struct packed {
      logic [15:0] count;
      logic [7:0] high_buf;
      logic [7:0] ctl;
      logic flag;
      logic irq_en;
      logic [1:0] clk_sel;
      logic idle_on_sleep;
      power_mode_e pmode;
      logic trig_pend;
      logic sca;
      logic lp;
      logic irq;
      logic adc;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } timer_state_s;

   timer_state_s s_q;
   timer_state_s s_d;

   logic raw_tick;
   logic inc_tick;
   logic ps_clear;
   logic on;
   logic wide;
   logic async_mode;
   logic access;
   logic wr;
   logic rd;
   logic setup;
   logic trig_now;
   logic trig_apply;
   logic cnt_wr;
   logic set_ovf;
   logic [15:0] count_nx;

   tick_source #(
      .DIV(INSTR_DIV)
   ) u_src (
      .core_clk(core_clk),
      .reset(reset),
      .src_sel(s_q.ctl[CTL_SRC]),
      .xtal_en(s_q.ctl[CTL_XTAL]),
      .ext_clk_in(ext_clk_in),
      .osc_clk_in(osc_clk_in),
      .raw_tick(raw_tick)
   );

   prescaler u_ps (
      .core_clk(core_clk),
      .reset(reset),
      .sel(s_q.ctl[CTL_PS_HI:CTL_PS_LO]),
      .clear(ps_clear),
      .tick(raw_tick && on),
      .out_tick(inc_tick)
   );

   always_comb begin
      s_d = s_q;
      on = s_q.ctl[CTL_ON];
      wide = s_q.ctl[CTL_WIDE];
      async_mode = s_q.ctl[CTL_SRC] && s_q.ctl[CTL_SYNC_BYP];
      setup = psel && !penable;
      access = psel && penable && s_q.ready;
      wr = access && pwrite;
      rd = access && !pwrite;
      cnt_wr = wr && ((paddr == OFS_COUNT_LOW) || ((paddr == OFS_COUNT_HIGH) && !wide));

      // special event from either compare unit
      trig_now = is_special_event(cmp_one) || is_special_event(cmp_two);
      // reset taken at the counting edge
      trig_apply = s_q.trig_pend && raw_tick && on;
      ps_clear = trig_apply || (wr && (paddr == OFS_COUNT_LOW));

      if (cnt_wr) begin
         s_d.trig_pend = 1'b0;
      end else if (trig_now && !async_mode) begin
         s_d.trig_pend = 1'b1;
      end else if (trig_apply) begin
         s_d.trig_pend = 1'b0;
      end

      count_nx = s_q.count;
      set_ovf = 1'b0;
      if (trig_apply) begin
         count_nx = COUNT_ZERO;
      end else if (inc_tick) begin
         count_nx = s_q.count + 16'h0001;
         // only a genuine wrap sets the flag
         set_ovf = (s_q.count == COUNT_MAX);
      end

      // Register writes override the running byte
      if (wr) begin
         if (paddr == OFS_COUNT_LOW) begin
            count_nx[7:0] = pwdata[7:0];
            // buffered high byte loads with low byte
            if (wide) begin
               count_nx[15:8] = s_q.high_buf;
            end
         end else if (paddr == OFS_COUNT_HIGH) begin
            // high byte only, low keeps running
            if (wide) begin
               s_d.high_buf = pwdata[7:0];
            end else begin
               count_nx[15:8] = pwdata[7:0];
            end
         end else if (paddr == OFS_CONTROL) begin
            s_d.ctl = pwdata[7:0] & CTL_WMASK;
         end else if (paddr == OFS_ENABLE) begin
            s_d.irq_en = pwdata[EN_OVF];
         end else if (paddr == OFS_OSC) begin
            s_d.clk_sel = pwdata[OSC_SEL_HI:OSC_SEL_LO];
            s_d.idle_on_sleep = pwdata[OSC_IDLE];
         end
      end
      s_d.count = count_nx;

      // low read snapshots the true high byte
      if (rd && wide && (paddr == OFS_COUNT_LOW)) begin
         s_d.high_buf = s_q.count[15:8];
      end

      // sticky flag, set beats software clear
      if (wr && (paddr == OFS_FLAG)) begin
         s_d.flag = set_ovf || pwdata[FLAG_OVF];
      end else begin
         s_d.flag = s_q.flag || set_ovf;
      end

      s_d.irq = s_d.flag && s_d.irq_en;
      s_d.adc = is_special_event(cmp_two) && adc_enable;

      // Power mode sequencing
      case (s_q.pmode)
         PM_PRIMARY: begin
            if (s_q.clk_sel == SCS_SECONDARY) begin
               s_d.pmode = PM_SEC_RUN;
            end
         end
         PM_SEC_RUN: begin
            if (s_q.clk_sel != SCS_SECONDARY) begin
               s_d.pmode = PM_PRIMARY;
            end else if (sleep_exec && !s_q.idle_on_sleep) begin
               s_d.pmode = PM_SEC_IDLE;
            end
         end
         PM_SEC_IDLE: begin
            if (wake_event) begin
               s_d.pmode = PM_SEC_RUN;
            end
         end
         default: begin
            s_d.pmode = PM_PRIMARY;
         end
      endcase

      s_d.sca = (s_d.pmode != PM_PRIMARY) && !(monitor_enable && osc_fail);
      s_d.lp = low_power_cfg;

      // APB answer prepared in the setup cycle
      s_d.ready = setup;
      s_d.err = 1'b0;
      s_d.rdata = '0;
      if (setup) begin
         if (paddr == OFS_COUNT_LOW) begin
            s_d.rdata[7:0] = s_q.count[7:0];
         end else if (paddr == OFS_COUNT_HIGH) begin
            s_d.rdata[7:0] = wide ? s_q.high_buf : s_q.count[15:8];
         end else if (paddr == OFS_CONTROL) begin
            s_d.rdata[7:0] = s_q.ctl;
            s_d.rdata[CTL_RUN] = s_q.sca;
         end else if (paddr == OFS_FLAG) begin
            s_d.rdata[FLAG_OVF] = s_q.flag;
         end else if (paddr == OFS_ENABLE) begin
            s_d.rdata[EN_OVF] = s_q.irq_en;
         end else if (paddr == OFS_OSC) begin
            s_d.rdata[OSC_SEL_HI:OSC_SEL_LO] = s_q.clk_sel;
            s_d.rdata[OSC_IDLE] = s_q.idle_on_sleep;
         end else begin
            s_d.err = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata = s_q.rdata;
   assign pready = s_q.ready;
   assign pslverr = s_q.err;
   assign adc_start = s_q.adc;
   assign system_clock_select = s_q.clk_sel;
   assign sec_run_mode = (s_q.pmode == PM_SEC_RUN);
   assign sec_idle_mode = (s_q.pmode == PM_SEC_IDLE);
   assign secondary_clock_active = s_q.sca;
   assign osc_low_power_mode = s_q.lp;
   assign crystal_osc_on = s_q.ctl[CTL_XTAL];
   assign overflow_irq = s_q.irq;
endmodule : event_timer

// ==== tb/event_timer_monitor.sv ====
// Port checker for the event timer.
// Assumes it sees only the top ports, bound below.
`timescale 1ns/10ps
module event_timer_monitor
   import timer_pkg::*;
(
   // Clock, reset and bus
   input wire logic core_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // Side ports
   input wire cmp_trig_s cmp_two,
   input wire logic adc_enable,
   input wire logic adc_start,
   input wire logic sleep_exec,
   input wire logic monitor_enable,
   input wire logic osc_fail,
   input wire logic low_power_cfg,
   input wire logic [1:0] system_clock_select,
   input wire logic sec_run_mode,
   input wire logic sec_idle_mode,
   input wire logic secondary_clock_active,
   input wire logic osc_low_power_mode,
   input wire logic crystal_osc_on
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   sequence s_sel_primary;
      system_clock_select == SCS_SECONDARY && !sec_run_mode && !sec_idle_mode;
   endsequence
   sequence s_ctl_wr;
      psel && penable && pready && pwrite && paddr == OFS_CONTROL;
   endsequence
   property p_run; s_sel_primary |-> ##[1:2] sec_run_mode; endproperty
   a_run: assert property (p_run) else $error("run mode missed");
   property p_idle; $rose(sec_idle_mode) |-> $past(sec_run_mode && sleep_exec); endproperty
   a_idle: assert property (p_idle) else $error("idle without sleep");
   property p_act;
      !$past(reset) |-> secondary_clock_active ==
         ((sec_run_mode || sec_idle_mode) && !$past(monitor_enable && osc_fail));
   endproperty
   a_act: assert property (p_act) else $error("clock status wrong");
   property p_fail; monitor_enable && osc_fail |=> !secondary_clock_active; endproperty
   a_fail: assert property (p_fail) else $error("failed osc shown active");
   property p_lp; !$past(reset) |-> osc_low_power_mode == $past(low_power_cfg); endproperty
   a_lp: assert property (p_lp) else $error("power option wrong");
   property p_adc;
      !$past(reset) |-> adc_start ==
         $past(cmp_two.mode == MODE_SPECIAL_EVENT && cmp_two.fire && adc_enable);
   endproperty
   a_adc: assert property (p_adc) else $error("conversion start wrong");
   property p_xtal; s_ctl_wr |-> ##2 crystal_osc_on == $past(pwdata[CTL_XTAL], 2); endproperty
   a_xtal: assert property (p_xtal) else $error("crystal enable wrong");
   property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
   a_rdy: assert property (p_rdy) else $error("ready timing wrong");
endmodule : event_timer_monitor

bind event_timer event_timer_monitor i_event_timer_monitor (.core_clk, .reset, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .cmp_two, .adc_enable, .adc_start,
   .sleep_exec, .monitor_enable, .osc_fail, .low_power_cfg, .system_clock_select,
   .sec_run_mode, .sec_idle_mode, .secondary_clock_active, .osc_low_power_mode,
   .crystal_osc_on);

// ==== tb/clock_pin_model.sv ====
// Clock pin model: free running crystal and external clock levels.
// Assumes pins are sampled on core_clk rising edges.
`timescale 1ns/10ps
module clock_pin_model #(
   parameter int EXT_HALF = 2,
   parameter int OSC_HALF = 5
) (
   // Core clock
   input wire logic core_clk,
   // Pin levels
   output logic ext_clk_in,
   output logic osc_clk_in
);
   int tc = 0;
   initial begin
      ext_clk_in = 1'b0;
      osc_clk_in = 1'b0;
   end
   always @(posedge core_clk) begin
      tc <= tc + 1;
      ext_clk_in <= 1'((tc / EXT_HALF) % 2);
      osc_clk_in <= 1'((tc / OSC_HALF) % 2);
   end
endmodule : clock_pin_model

// ==== tb/sixteen_bit_timer_with_event_reset_tb.sv ====
// Self-checking bench for the event timer and clock pin model.
// Assumes zero-wait APB and byte registers in bits 7:0.
`timescale 1ns/10ps
module sixteen_bit_timer_with_event_reset_tb;
   import timer_pkg::*;
   logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, er, ext_clk_in, osc_clk_in, adc_enable = 1'b0, adc_start;
   cmp_trig_s cmp_one = '0, cmp_two = '0;
   logic sleep_exec = 1'b0, wake_event = 1'b0, monitor_enable = 1'b0, osc_fail = 1'b0;
   logic low_power_cfg = 1'b0, sec_run_mode, sec_idle_mode, secondary_clock_active;
   logic osc_low_power_mode, crystal_osc_on, overflow_irq;
   logic [1:0] system_clock_select;
   int err_total = 0, comparisons = 0, seed = 32'haf504ef2, v;

   always #12.5 core_clk = !core_clk;

   event_timer i_event_timer (.*);
   clock_pin_model i_clock_pin_model (.*);

   task automatic close_out;
      $display("Counts: %0d compares, %0d mismatches", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : cyc

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 10);
      rd = prdata;
      er = pslverr;
      if (n >= 10) begin
         err_total++;
         close_out();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rdchk

   task automatic run_count(input logic [31:0] ctl, input int w, input int lo, input int hi);
      apb(1'b1, OFS_COUNT_HIGH, 32'h0);
      apb(1'b1, OFS_COUNT_LOW, 32'h0);
      apb(1'b1, OFS_CONTROL, ctl);
      cyc(w);
      apb(1'b1, OFS_CONTROL, 32'h0);
      apb(1'b0, OFS_COUNT_LOW, 32'h0);
      check(32'(rd >= lo && rd <= hi), 32'h1);
   endtask : run_count

   initial begin
      cyc(4);
      reset <= 1'b0;
      for (int a = 0; a < 24; a += 4) rdchk(8'(a), 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      check(32'(er), 32'h1);
      apb(1'b1, OFS_CONTROL, 32'hc0);
      rdchk(OFS_CONTROL, 32'h80);
      $display("test registers done");
      apb(1'b1, OFS_ENABLE, 32'h1);
      apb(1'b1, OFS_COUNT_HIGH, 32'hff);
      apb(1'b1, OFS_COUNT_LOW, 32'hfe);
      apb(1'b1, OFS_CONTROL, 32'h01);
      cyc(16);
      apb(1'b1, OFS_CONTROL, 32'h00);
      rdchk(OFS_COUNT_HIGH, 32'h0);
      rdchk(OFS_FLAG, 32'h1);
      check(32'(overflow_irq), 32'h1);
      apb(1'b1, OFS_ENABLE, 32'h0);
      cyc(2);
      check(32'(overflow_irq), 32'h0);
      apb(1'b1, OFS_FLAG, 32'h0);
      rdchk(OFS_FLAG, 32'h0);
      apb(1'b1, OFS_COUNT_LOW, 32'h5a);
      cyc(40);
      rdchk(OFS_COUNT_LOW, 32'h5a);
      $display("test overflow done");
      for (int p = 0; p < 4; p++) run_count(32'((p << CTL_PS_LO) | 1), 32 << p, 7, 9);
      run_count(32'h03, 40, 9, 12);
      run_count(32'h0b, 40, 3, 5);
      $display("test sources done");
      repeat (4) begin
         v = $random(seed);
         apb(1'b1, OFS_COUNT_HIGH, {25'h0, v[14:8]});
         apb(1'b1, OFS_COUNT_LOW, {24'h0, v[7:0]});
         apb(1'b1, OFS_COUNT_HIGH, {24'h0, 1'b1, v[14:8]});
         rdchk(OFS_COUNT_LOW, {24'h0, v[7:0]});
         apb(1'b1, OFS_CONTROL, 32'h80);
         apb(1'b1, OFS_COUNT_HIGH, {24'h0, v[23:16]});
         rdchk(OFS_COUNT_LOW, {24'h0, v[7:0]});
         rdchk(OFS_COUNT_HIGH, {24'h0, 1'b1, v[14:8]});
         apb(1'b1, OFS_COUNT_HIGH, {24'h0, v[23:16]});
         apb(1'b1, OFS_COUNT_LOW, {24'h0, v[31:24]});
         apb(1'b1, OFS_CONTROL, 32'h0);
         rdchk(OFS_COUNT_HIGH, {24'h0, v[23:16]});
      end
      $display("test byte access done");
      adc_enable <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         apb(1'b1, OFS_COUNT_HIGH, 32'h40);
         apb(1'b1, OFS_COUNT_LOW, 32'h0);
         apb(1'b1, OFS_CONTROL, 32'h1);
         if (i[4]) cmp_two <= '{i[3:0], 1'b1};
         else cmp_one <= '{i[3:0], 1'b1};
         @(posedge core_clk);
         cmp_one <= '0;
         cmp_two <= '0;
         cyc(8);
         apb(1'b1, OFS_CONTROL, 32'h0);
         rdchk(OFS_COUNT_HIGH, (i[3:0] == MODE_SPECIAL_EVENT) ? 32'h0 : 32'h40);
         rdchk(OFS_FLAG, 32'h0);
      end
      apb(1'b1, OFS_COUNT_HIGH, 32'h42);
      cmp_one <= '{MODE_SPECIAL_EVENT, 1'b1};
      @(posedge core_clk);
      cmp_one <= '0;
      apb(1'b1, OFS_COUNT_LOW, 32'h77);
      apb(1'b1, OFS_CONTROL, 32'h1);
      cyc(8);
      apb(1'b1, OFS_CONTROL, 32'h0);
      rdchk(OFS_COUNT_HIGH, 32'h42);
      $display("test triggers done");
      apb(1'b1, OFS_OSC, 32'h01);
      cyc(3);
      check(32'(sec_run_mode), 32'h1);
      rdchk(OFS_CONTROL, 32'h40);
      sleep_exec <= 1'b1;
      @(posedge core_clk);
      sleep_exec <= 1'b0;
      cyc(2);
      check(32'(sec_idle_mode), 32'h1);
      monitor_enable <= 1'b1;
      osc_fail <= 1'b1;
      cyc(3);
      check(32'(secondary_clock_active), 32'h0);
      osc_fail <= 1'b0;
      wake_event <= 1'b1;
      @(posedge core_clk);
      wake_event <= 1'b0;
      apb(1'b1, OFS_OSC, 32'h00);
      cyc(3);
      check(32'(secondary_clock_active), 32'h0);
      low_power_cfg <= 1'b1;
      cyc(2);
      check(32'(osc_low_power_mode), 32'h1);
      $display("test power done");
      close_out();
   end
endmodule : sixteen_bit_timer_with_event_reset_tb
